/* core/vcb_map.vh */
// register map, field positions and timing figures of the serial bridge
`ifndef VCB_MAP_VH
`define VCB_MAP_VH

// register byte offsets
`define VCB_OFS_CTRL 8'h00
`define VCB_OFS_BAUD 8'h04
`define VCB_OFS_TXDATA 8'h08
`define VCB_OFS_RXDATA 8'h0c
`define VCB_OFS_STATUS 8'h10

// control register: handshake mode in bits 1:0
`define VCB_HS_OFF 2'h0
`define VCB_HS_RTS 2'h1
`define VCB_HS_CTS 2'h2
`define VCB_HS_BOTH 2'h3
`define VCB_HS_DRIVE_BIT 0
`define VCB_HS_GATE_BIT 1
`define VCB_CTRL_RESET 2'h0

// rx data register: valid flag above the byte
`define VCB_RXD_VALID_BIT 8

// status register bits
`define VCB_ST_TXFULL 0
`define VCB_ST_TXIDLE 1
`define VCB_ST_RXVALID 2
`define VCB_ST_RXFULL 3
`define VCB_ST_LINKEN 4
`define VCB_ST_TGTREADY 5
`define VCB_ST_OVERRUN 6
`define VCB_ST_FRAMEERR 7
`define VCB_ST_TXDROP 8

// clock and bit-rate figures
`define VCB_CLK_HZ 25000000
`define VCB_BAUD_DEF 115200
`define VCB_BAUD_MIN 9600
`define VCB_BAUD_MAX 921600
`define VCB_DIV_DEF (`VCB_CLK_HZ / `VCB_BAUD_DEF)
`define VCB_DIV_SLOW (`VCB_CLK_HZ / `VCB_BAUD_MIN)
`define VCB_DIV_FAST (`VCB_CLK_HZ / `VCB_BAUD_MAX)

`endif

/* core/vcb_sync.v */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module vcb_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clk, // system clock
    input wire arst_n, // async reset, active low
    input wire [W-1:0] pinIn, // raw pin levels
    output reg [W-1:0] syncOut // levels safe to use
);

reg [W-1:0] stage1_r;

// first stage feeds only the second stage
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        stage1_r <= INIT;
        syncOut <= INIT;
    end
    else
    begin
        stage1_r <= pinIn;
        syncOut <= stage1_r;
    end
end

endmodule

/* core/vcb_fifo2.v */
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module vcb_fifo2 #(
    parameter W = 8
) (
    input wire clk, // system clock
    input wire arst_n, // async reset, active low
    input wire [W-1:0] inData, // word to store
    input wire inValid, // word offered
    output wire inReady, // room for a word
    output wire [W-1:0] outData, // oldest word
    output wire outValid, // a word is held
    input wire outReady // drain takes the word
);

reg [W-1:0] slot0_r;
reg [W-1:0] slot1_r;
reg [1:0] count_r;
wire doPush;
wire doPop;

assign inReady = (count_r != 2'd2);
assign outValid = (count_r != 2'd0);
assign outData = slot0_r;
assign doPush = inValid && inReady;
assign doPop = outValid && outReady;

// slot0 is always the head; slot1 shifts down on a pop
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        slot0_r <= {W{1'b0}};
        slot1_r <= {W{1'b0}};
        count_r <= 2'd0;
    end
    else
    begin
        if (doPop)
        begin
            slot0_r <= (doPush && count_r == 2'd1) ? inData : slot1_r;
        end
        else if (doPush && count_r == 2'd0)
        begin
            slot0_r <= inData;
        end
        if (doPush && ((count_r == 2'd1 && !doPop) || count_r == 2'd2))
        begin
            slot1_r <= inData;
        end
        if (doPush && !doPop)
        begin
            count_r <= count_r + 2'd1;
        end
        else if (doPop && !doPush)
        begin
            count_r <= count_r - 2'd1;
        end
    end
end

endmodule

/* core/vcb_uart_bridge.v */
// controller-side serial bridge with handshake, reached over AHB-Lite
//
// How it works
// - the link has a data line each way, two flow-control lines and an enable line.
// - the target transmit line brings bytes in, the target receive line carries them out.
// - no character is started or taken while the enable line from the target is low.
// - after reset the link runs 115200 baud 8N1 with handshake off and its inputs ignored.
// - the bit rate is programmable between 9600 and 921600 bit/s, writes are clamped.
// - with output flow control on, clear-to-send is low while room remains, high when full.
// - with input flow control on, no new character goes out while request-to-send is high.
// - a character already started always completes, whatever request-to-send does.
// - mode disabled leaves clear-to-send undriven and ignores request-to-send.
// - mode rts drives clear-to-send from buffer room and ignores request-to-send.
// - mode cts leaves clear-to-send undriven and gates sending on request-to-send.
// - mode rtscts drives clear-to-send and gates sending on request-to-send.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "vcb_map.vh"
module vcb_uart_bridge (
    input wire clk, // 25 MHz system clock
    input wire arst_n, // async reset, active low
    input wire hsel, // slave select
    input wire [7:0] haddr, // byte address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write when high
    input wire [2:0] hsize, // transfer size, word only
    input wire hready, // bus ready
    input wire [31:0] hwdata, // write data
    output reg [31:0] hrdata, // read data
    output reg hreadyout, // slave ready
    output reg hresp, // always okay
    input wire tgtTxd, // target transmit line, bytes in
    output reg tgtRxd, // target receive line, bytes out
    output reg tgtCts_n, // target clear-to-send level
    output reg tgtCtsOe, // clear-to-send driven when high
    input wire tgtRts_n, // target request-to-send
    input wire linkEnable // interface enable from target
);

localparam integer DIV_DEF_I = `VCB_DIV_DEF;
localparam integer DIV_SLOW_I = `VCB_DIV_SLOW;
localparam integer DIV_FAST_I = `VCB_DIV_FAST;
localparam [11:0] DIV_DEF = DIV_DEF_I[11:0];
localparam [11:0] DIV_SLOW = DIV_SLOW_I[11:0];
localparam [11:0] DIV_FAST = DIV_FAST_I[11:0];

// receiver states
localparam RX_IDLE = 2'd0;
localparam RX_START = 2'd1;
localparam RX_DATA = 2'd2;
localparam RX_STOP = 2'd3;

reg [1:0] mode_r;
reg [11:0] div_r;
reg overrun_r;
reg frameErr_r;
reg txDrop_r;
reg wrPend_r;
reg [7:0] wrAddr_r;
reg txPush_r;
reg [7:0] txPushData_r;
reg [1:0] rxState_r;
reg [11:0] rxCnt_r;
reg [2:0] rxBit_r;
reg [7:0] rxShift_r;
reg rxPush_r;
reg txBusy_r;
reg [11:0] txCnt_r;
reg [3:0] txBit_r;
reg [8:0] txShift_r;
reg [31:0] rdMux;
reg [11:0] wrDiv;

wire rxdS;
wire rtsS_n;
wire linkEnS;
wire busTake;
wire rdRx;
wire txInReady;
wire [7:0] txOutData;
wire txOutValid;
wire txStart;
wire rxInReady;
wire [7:0] rxOutData;
wire rxOutValid;
wire gateOk;

// pin inputs: enable resets low, lines idle high
vcb_sync #(.W(3), .INIT(3'b011)) uSync (
    .clk(clk),
    .arst_n(arst_n),
    .pinIn({linkEnable, tgtRts_n, tgtTxd}),
    .syncOut({linkEnS, rtsS_n, rxdS})
);

// bytes from host toward target
vcb_fifo2 #(.W(8)) uTxBuf (
    .clk(clk),
    .arst_n(arst_n),
    .inData(txPushData_r),
    .inValid(txPush_r),
    .inReady(txInReady),
    .outData(txOutData),
    .outValid(txOutValid),
    .outReady(txStart)
);

// bytes from target toward host
vcb_fifo2 #(.W(8)) uRxBuf (
    .clk(clk),
    .arst_n(arst_n),
    .inData(rxShift_r),
    .inValid(rxPush_r),
    .inReady(rxInReady),
    .outData(rxOutData),
    .outValid(rxOutValid),
    .outReady(rdRx)
);

assign busTake = hsel && htrans[1] && hready;
assign rdRx = busTake && !hwrite && haddr == `VCB_OFS_RXDATA && rxOutValid;
// request-to-send counts only in modes cts and rtscts
assign gateOk = !mode_r[`VCB_HS_GATE_BIT] || !rtsS_n;
// a new character needs a word, an idle shifter, the enable and the gate
assign txStart = txOutValid && !txBusy_r && linkEnS && gateOk;

// read data chosen in the address phase, registered into the data phase
always @*
begin
    rdMux = 32'h0000_0000;
    case (haddr)
        `VCB_OFS_CTRL: rdMux[1:0] = mode_r;
        `VCB_OFS_BAUD: rdMux[11:0] = div_r;
        `VCB_OFS_RXDATA:
        begin
            rdMux[7:0] = rxOutData;
            rdMux[`VCB_RXD_VALID_BIT] = rxOutValid;
        end
        `VCB_OFS_STATUS:
        begin
            rdMux[`VCB_ST_TXFULL] = !txInReady;
            rdMux[`VCB_ST_TXIDLE] = !txBusy_r && !txOutValid;
            rdMux[`VCB_ST_RXVALID] = rxOutValid;
            rdMux[`VCB_ST_RXFULL] = !rxInReady;
            rdMux[`VCB_ST_LINKEN] = linkEnS;
            rdMux[`VCB_ST_TGTREADY] = !rtsS_n;
            rdMux[`VCB_ST_OVERRUN] = overrun_r;
            rdMux[`VCB_ST_FRAMEERR] = frameErr_r;
            rdMux[`VCB_ST_TXDROP] = txDrop_r;
        end
        default: rdMux = 32'h0000_0000;
    endcase
end

// divisor writes clamped into the legal bit-rate range
always @*
begin
    wrDiv = hwdata[11:0];
    if (hwdata[31:12] != 20'h0_0000 || hwdata[11:0] > DIV_SLOW)
    begin
        wrDiv = DIV_SLOW;
    end
    else if (hwdata[11:0] < DIV_FAST)
    begin
        wrDiv = DIV_FAST;
    end
end

// bus slave: zero wait states, every answer okay
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        hrdata <= 32'h0000_0000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wrPend_r <= 1'b0;
        wrAddr_r <= 8'h00;
        mode_r <= `VCB_CTRL_RESET;
        div_r <= DIV_DEF;
        txPush_r <= 1'b0;
        txPushData_r <= 8'h00;
    end
    else
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wrPend_r <= busTake && hwrite;
        if (busTake)
        begin
            wrAddr_r <= haddr;
        end
        if (busTake && !hwrite)
        begin
            hrdata <= rdMux;
        end
        txPush_r <= 1'b0;
        if (wrPend_r)
        begin
            case (wrAddr_r)
                `VCB_OFS_CTRL: mode_r <= hwdata[1:0];
                `VCB_OFS_BAUD: div_r <= wrDiv;
                `VCB_OFS_TXDATA:
                begin
                    txPush_r <= 1'b1;
                    txPushData_r <= hwdata[7:0];
                end
                default: txPush_r <= 1'b0;
            endcase
        end
    end
end

// sticky flags: hardware set wins over a write-one clear
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        overrun_r <= 1'b0;
        frameErr_r <= 1'b0;
        txDrop_r <= 1'b0;
    end
    else
    begin
        if (rxPush_r && !rxInReady)
        begin
            overrun_r <= 1'b1;
        end
        else if (wrPend_r && wrAddr_r == `VCB_OFS_STATUS && hwdata[`VCB_ST_OVERRUN])
        begin
            overrun_r <= 1'b0;
        end
        if (rxState_r == RX_STOP && rxCnt_r == 12'h000 && !rxdS)
        begin
            frameErr_r <= 1'b1;
        end
        else if (wrPend_r && wrAddr_r == `VCB_OFS_STATUS && hwdata[`VCB_ST_FRAMEERR])
        begin
            frameErr_r <= 1'b0;
        end
        if (txPush_r && !txInReady)
        begin
            txDrop_r <= 1'b1;
        end
        else if (wrPend_r && wrAddr_r == `VCB_OFS_STATUS && hwdata[`VCB_ST_TXDROP])
        begin
            txDrop_r <= 1'b0;
        end
    end
end

// clear-to-send: low while the rx buffer has room, driven only in rts modes
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        tgtCts_n <= 1'b1;
        tgtCtsOe <= 1'b0;
    end
    else
    begin
        tgtCts_n <= !rxInReady;
        tgtCtsOe <= mode_r[`VCB_HS_DRIVE_BIT];
    end
end

// transmitter: once started a character always runs to its stop bit
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        tgtRxd <= 1'b1;
        txBusy_r <= 1'b0;
        txCnt_r <= 12'h000;
        txBit_r <= 4'h0;
        txShift_r <= 9'h1ff;
    end
    else if (txStart)
    begin
        tgtRxd <= 1'b0;
        txShift_r <= {1'b1, txOutData};
        txBusy_r <= 1'b1;
        txCnt_r <= div_r - 12'h001;
        txBit_r <= 4'h0;
    end
    else if (txBusy_r)
    begin
        if (txCnt_r != 12'h000)
        begin
            txCnt_r <= txCnt_r - 12'h001;
        end
        else if (txBit_r == 4'h9)
        begin
            txBusy_r <= 1'b0;
        end
        else
        begin
            tgtRxd <= txShift_r[0];
            txShift_r <= {1'b1, txShift_r[8:1]};
            txBit_r <= txBit_r + 4'h1;
            txCnt_r <= div_r - 12'h001;
        end
    end
end

// receiver: mid-bit sampling; a rate change mid-character garbles that one
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        rxState_r <= RX_IDLE;
        rxCnt_r <= 12'h000;
        rxBit_r <= 3'h0;
        rxShift_r <= 8'h00;
        rxPush_r <= 1'b0;
    end
    else
    begin
        rxPush_r <= 1'b0;
        if (rxCnt_r != 12'h000)
        begin
            rxCnt_r <= rxCnt_r - 12'h001;
        end
        case (rxState_r)
            RX_IDLE:
            begin
                if (!rxdS && linkEnS)
                begin
                    rxState_r <= RX_START;
                    rxCnt_r <= {1'b0, div_r[11:1]};
                end
            end
            RX_START:
            begin
                if (rxCnt_r == 12'h000)
                begin
                    // a glitch shorter than half a bit is not a start
                    rxState_r <= rxdS ? RX_IDLE : RX_DATA;
                    rxCnt_r <= div_r - 12'h001;
                    rxBit_r <= 3'h0;
                end
            end
            RX_DATA:
            begin
                if (rxCnt_r == 12'h000)
                begin
                    rxShift_r <= {rxdS, rxShift_r[7:1]};
                    rxCnt_r <= div_r - 12'h001;
                    rxBit_r <= rxBit_r + 3'h1;
                    if (rxBit_r == 3'h7)
                    begin
                        rxState_r <= RX_STOP;
                    end
                end
            end
            RX_STOP:
            begin
                if (rxCnt_r == 12'h000)
                begin
                    rxPush_r <= rxdS && linkEnS;
                    rxState_r <= RX_IDLE;
                end
            end
            default: rxState_r <= RX_IDLE;
        endcase
    end
end

endmodule

/* verification/vcb_bridge_props.sv */
// port-level assertion checker for the serial bridge
`timescale 1ns/10ps
`include "vcb_map.vh"
module vcb_bridge_props (
    input logic clk, arst_n, hsel, hwrite, hready, // clock, reset, bus controls
    input logic [7:0] haddr, // byte address
    input logic [1:0] htrans, // transfer type
    input logic [2:0] hsize, // transfer size
    input logic [31:0] hwdata, hrdata, // bus data
    input logic hreadyout, hresp, // slave answer
    input logic tgtTxd, tgtRxd, tgtCts_n, tgtCtsOe, tgtRts_n, linkEnable // link pins
);
    logic wrPend;
    logic [7:0] wrAddr;
    logic [1:0] modeR;
    int div, busyCnt, modeAge;
    // shadow mode and divisor from bus writes; busyCnt spans one outgoing frame
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            modeR <= `VCB_CTRL_RESET;
            modeAge <= 3;
            div <= `VCB_DIV_DEF;
            busyCnt <= 0;
        end
        else
        begin
            if (hready)
            begin
                wrPend <= hsel && htrans[1] && hwrite;
                wrAddr <= haddr;
            end
            if (hready && wrPend && wrAddr == `VCB_OFS_CTRL)
            begin
                modeR <= hwdata[1:0];
                modeAge <= 0;
            end
            else if (modeAge < 3)
                modeAge <= modeAge + 1;
            // writes are clamped into the legal divisor range
            if (hready && wrPend && wrAddr == `VCB_OFS_BAUD)
                div <= (hwdata[31:12] != 0 || hwdata[11:0] > `VCB_DIV_SLOW) ? `VCB_DIV_SLOW :
                    (hwdata[11:0] < `VCB_DIV_FAST ? `VCB_DIV_FAST : hwdata[11:0]);
            if (busyCnt != 0)
                busyCnt <= busyCnt - 1;
            else if ($fell(tgtRxd))
                busyCnt <= 10 * div;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // the line has been idle for four samples under a hold-off condition
    sequence idleHeld(cond);
        (busyCnt == 0 && cond)[*4];
    endsequence
    oe_mode_a:
        assert property (modeAge == 3 |-> tgtCtsOe == modeR[0])
        else $error("clear-to-send drive disagrees with mode");
    start_gated_a:
        assert property (idleHeld(modeR[1] && tgtRts_n) |=> !$fell(tgtRxd))
        else $error("character started while target not ready");
    enable_gate_a:
        assert property (idleHeld(!linkEnable) |=> !$fell(tgtRxd))
        else $error("character started while link disabled");
    idle_high_a:
        assert property (busyCnt == 0 |-> tgtRxd || $fell(tgtRxd))
        else $error("line low outside a frame");
    start_low_a:
        assert property (busyCnt == 10 * div - div / 2 |-> !tgtRxd)
        else $error("start bit not low");
    stop_high_a:
        assert property (busyCnt != 0 && busyCnt == div / 2 |-> tgtRxd)
        else $error("stop bit not high");
    bit_timing_a:
        assert property (busyCnt != 0 && (busyCnt - 1) % div != 0 |-> $stable(tgtRxd))
        else $error("line changed inside a bit");
    okay_resp_a:
        assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
endmodule

/* verification/vcb_tgt_model.sv */
// behavioural target-side serial peer
`timescale 1ns/10ps
module vcb_tgt_model (
    input logic clk, // system clock
    input logic rxLine, // bytes from the bridge
    input logic ctsLevel, ctsOe, // clear-to-send pin and its drive
    input logic rdy, // target can take data
    input logic ctsEn, // target honours clear-to-send
    input int div, // clock cycles per bit
    output logic txLine, // bytes to the bridge
    output logic rtsLevel // request-to-send pin
);
    logic [7:0] rxQ[$];
    logic [7:0] rb;
    logic ctsW;
    // an undriven clear-to-send floats to its pull-up: not ready
    assign ctsW = ctsOe ? ctsLevel : 1'b1;
    // ready shows as a low level
    assign rtsLevel = !rdy;
    initial txLine = 1'b1;
    // one character out, held back while the bridge is full
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (ctsEn && ctsW)
            @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
            txLine <= f[i];
            repeat (div) @(posedge clk);
        end
    endtask
    // receiver takes every character with a high stop bit, also one after ready drops
    always
    begin
        @(posedge clk);
        if (!rxLine)
        begin
            repeat (div / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (div) @(posedge clk);
                rb[i] = rxLine;
            end
            repeat (div) @(posedge clk);
            if (rxLine)
                rxQ.push_back(rb);
        end
    end
endmodule

/* verification/tb_top.sv */
// self-checking bench for the serial bridge
`timescale 1ns/10ps
`include "vcb_map.vh"
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, linkEnable = 1'b0, rdy = 1'b1, ctsEn = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, d;
    wire [31:0] hrdata;
    wire hreadyout, hresp, tgtTxd, tgtRxd, tgtCts_n, tgtCtsOe, tgtRts_n;
    int div = `VCB_DIV_DEF;
    int errors = 0, numChecks = 0, cyc = 0;
    vcb_uart_bridge u_vcb_uart_bridge (.clk(clk), .arst_n(arst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .tgtTxd(tgtTxd), .tgtRxd(tgtRxd), .tgtCts_n(tgtCts_n), .tgtCtsOe(tgtCtsOe),
        .tgtRts_n(tgtRts_n), .linkEnable(linkEnable));
    vcb_tgt_model u_vcb_tgt_model (.clk(clk), .rxLine(tgtRxd), .ctsLevel(tgtCts_n),
        .ctsOe(tgtCtsOe), .rdy(rdy), .ctsEn(ctsEn), .div(div), .txLine(tgtTxd),
        .rtsLevel(tgtRts_n));
    // 25 MHz clock
    initial forever #20 clk = ~clk;
    // hang guard, well above the expected run
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            errors++;
            test_done();
        end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one single transfer; address held until ready, then data phase
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (!hreadyout);
        d = hrdata;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(a, 1'b0, 32'h0);
        chk(what, exp, d);
    endtask
    task automatic rxByte(input logic [7:0] e);
        for (int k = 0; k < 5000 && u_vcb_tgt_model.rxQ.size() == 0; k++)
            @(posedge clk);
        chk("target byte", {24'h0, e}, u_vcb_tgt_model.rxQ.pop_front());
    endtask
    task automatic t_reset;
        rdChk(`VCB_OFS_CTRL, 32'h0, "ctrl");
        rdChk(`VCB_OFS_BAUD, 32'hd9, "baud");
        chk("cts drive", 32'h0, tgtCtsOe);
        rdChk(8'h14, 32'h0, "unmapped");
        rdy <= 1'b0;
        bus(`VCB_OFS_TXDATA, 1'b1, 32'ha5);
        rxByte(8'ha5);
        rdy <= 1'b1;
        $display("test reset done");
    endtask
    task automatic t_baud;
        bus(`VCB_OFS_BAUD, 1'b1, 32'h1a);
        rdChk(`VCB_OFS_BAUD, 32'h1b, "baud low");
        bus(`VCB_OFS_BAUD, 1'b1, 32'h1000);
        rdChk(`VCB_OFS_BAUD, 32'ha2c, "baud high");
        bus(`VCB_OFS_BAUD, 1'b1, 32'h1b);
        div = 27;
        u_vcb_tgt_model.sendByte(8'h3c);
        repeat (4) @(posedge clk);
        rdChk(`VCB_OFS_RXDATA, 32'h13c, "rx byte");
        bus(`VCB_OFS_TXDATA, 1'b1, 32'h5a);
        rxByte(8'h5a);
        $display("test baud done");
    endtask
    task automatic t_gate(input logic [1:0] m);
        bus(`VCB_OFS_CTRL, 1'b1, {30'h0, m});
        rdy <= 1'b0;
        repeat (4) @(posedge clk);
        bus(`VCB_OFS_TXDATA, 1'b1, 32'h11);
        bus(`VCB_OFS_TXDATA, 1'b1, 32'h22);
        bus(`VCB_OFS_TXDATA, 1'b1, 32'h33);
        repeat (400) @(posedge clk);
        chk("held", 32'h0, u_vcb_tgt_model.rxQ.size());
        rdChk(`VCB_OFS_STATUS, 32'h111, "status");
        chk("drop full", 32'h101, d & 32'h101);
        bus(`VCB_OFS_STATUS, 1'b1, 32'h100);
        rdy <= 1'b1;
        rxByte(8'h11);
        rxByte(8'h22);
        bus(`VCB_OFS_TXDATA, 1'b1, 32'h44);
        repeat (60) @(posedge clk);
        rdy <= 1'b0;
        rxByte(8'h44);
        rdy <= 1'b1;
        chk("cts drive", {31'h0, m[0]}, tgtCtsOe);
        $display("test gate done");
    endtask
    task automatic t_cts;
        bus(`VCB_OFS_CTRL, 1'b1, 32'h1);
        ctsEn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("cts drive", 32'h1, tgtCtsOe);
        chk("cts room", 32'h0, tgtCts_n);
        u_vcb_tgt_model.sendByte(8'h61);
        u_vcb_tgt_model.sendByte(8'h62);
        repeat (4) @(posedge clk);
        chk("cts full", 32'h1, tgtCts_n);
        // a third byte must wait inside the target until room returns
        fork
            u_vcb_tgt_model.sendByte(8'h63);
        join_none
        repeat (400) @(posedge clk);
        rdChk(`VCB_OFS_STATUS, 32'h3e, "held off");
        rdChk(`VCB_OFS_RXDATA, 32'h161, "rx first");
        repeat (4) @(posedge clk);
        chk("cts again", 32'h0, tgtCts_n);
        rdChk(`VCB_OFS_RXDATA, 32'h162, "rx second");
        repeat (300) @(posedge clk);
        rdChk(`VCB_OFS_RXDATA, 32'h163, "rx third");
        // undriven clear-to-send would stall the model in later tests
        ctsEn <= 1'b0;
        $display("test cts done");
    endtask
    task automatic t_enable;
        bus(`VCB_OFS_CTRL, 1'b1, 32'h0);
        linkEnable <= 1'b0;
        repeat (4) @(posedge clk);
        bus(`VCB_OFS_TXDATA, 1'b1, 32'h71);
        repeat (400) @(posedge clk);
        chk("tx off", 32'h0, u_vcb_tgt_model.rxQ.size());
        u_vcb_tgt_model.sendByte(8'h72);
        repeat (4) @(posedge clk);
        bus(`VCB_OFS_RXDATA, 1'b0, 32'h0);
        chk("rx off", 32'h0, d[8]);
        linkEnable <= 1'b1;
        rxByte(8'h71);
        $display("test enable done");
    endtask
    // reset, then the scenarios in turn
    initial
    begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        linkEnable <= 1'b1;
        @(posedge clk);
        t_reset();
        t_baud();
        t_gate(2'h2);
        t_gate(2'h3);
        t_cts();
        t_enable();
        test_done();
    end
endmodule
bind vcb_uart_bridge vcb_bridge_props u_vcb_bridge_props (.clk(clk), .arst_n(arst_n),
    .hsel(hsel), .hwrite(hwrite), .hready(hready), .haddr(haddr), .htrans(htrans),
    .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tgtTxd(tgtTxd), .tgtRxd(tgtRxd), .tgtCts_n(tgtCts_n), .tgtCtsOe(tgtCtsOe),
    .tgtRts_n(tgtRts_n), .linkEnable(linkEnable));
